// ===== logic/ahr_hist_mem.sv
`timescale 1ns/1ps
module ahr_hist_mem (
  input  wire logic                             clk,
  input  wire logic                             ce,
  input  wire logic                             we,
  input  wire logic [ahr_pkg::HIST_AW-1:0]      waddr,
  input  wire ahr_pkg::ahr_entry_t              wdata,
  input  wire logic [ahr_pkg::HIST_AW-1:0]      raddr,
  output ahr_pkg::ahr_entry_t                   rdata
);
  import ahr_pkg::*;
  ahr_entry_t mem [HIST_DEPTH];

  // Registered read; no reset so it maps onto RAM
  always_ff @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule

// ===== logic/ahr_pkg.sv
// Operation
// - Each entry stores a sub code; for data error it names the cause.
// - Capture driver temperature at the alarm.
// - Capture motor temperature at the alarm.
// - Capture inverter voltage at the alarm.
// - Latch direct input lines as a bit vector at the alarm.
// - Latch remote output bits as a bit vector at the alarm.
// - Remote output bits keep updating internally without any network link.
// - Record the operation data number executing at the alarm.
// - Record the numeric kind of operation running at the alarm.
// - Capture the feedback position counter at the alarm.
// - Count time since control power, else main power; store at alarm.
// - Count time since operation start; store at alarm.
// - Count time since main power; store at alarm.
// - Data error 01h when positioning travel is outside +/-2,147,483,647 steps.
// - Data error 02h when a wrap operation starts with wrap disabled.
// - Data error 03h when positioning starts with nonzero travel and zero speed.
// - Sensor limits selected: data error 04h if operating speed exceeds sensor maximum.
// - Sensor limits selected: data error 05h if starting speed exceeds sensor maximum.
// - Sensor limits selected: data error 06h if push speed exceeds sensor limit.
// - Sensor limits selected: data error 07h if push current exceeds sensor limit.
// - Sensor limits selected: data error 08h if any homing parameter exceeds sensor value.
package ahr_pkg;
  ////////////////////////////////////////////////////////////////////////////
  localparam int          HIST_DEPTH   = 8;
  localparam int          HIST_AW      = 3;
  localparam int          ENTRY_WORDS  = 16;
  localparam logic [7:0]  ALM_DATA_ERR = 8'h70;
  localparam logic [7:0]  SUB_NONE     = 8'h00;
  localparam logic [7:0]  SUB_TRAVEL   = 8'h01;
  localparam logic [7:0]  SUB_WRAP     = 8'h02;
  localparam logic [7:0]  SUB_ZSPEED   = 8'h03;
  localparam logic [7:0]  SUB_OPSPD    = 8'h04;
  localparam logic [7:0]  SUB_STSPD    = 8'h05;
  localparam logic [7:0]  SUB_PSHSPD   = 8'h06;
  localparam logic [7:0]  SUB_PSHCUR   = 8'h07;
  localparam logic [7:0]  SUB_HOME     = 8'h08;
  localparam logic signed [32:0] TRAVEL_MAX = 33'sh0_7fff_ffff;
  localparam logic signed [32:0] TRAVEL_MIN = -33'sh0_7fff_ffff;
  // Elapsed time tick: 1 ms at 125 MHz
  localparam int          TICK_NS      = 1000000;
  localparam int          CLK_NS       = 8;
  localparam int          TICK_CYC     = TICK_NS / CLK_NS;
  ////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_STAT     = 8'h04;
  localparam logic [7:0]  REG_SEL      = 8'h08;
  localparam logic [7:0]  REG_ROUT     = 8'h0c;
  localparam logic [7:0]  REG_ENTRY    = 8'h40;
  localparam int          CTRL_CLR     = 0;
  localparam int          CTRL_SENSLIM = 1;
  localparam int          CTRL_WRAPEN  = 2;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [7:0]  code;
    logic [7:0]  sub;
    logic [15:0] drv_temp;
    logic [15:0] mot_temp;
    logic [15:0] inv_volt;
    logic [31:0] din;
    logic [31:0] rout;
    logic [15:0] op_num;
    logic [15:0] op_kind;
    logic [31:0] fb_pos;
    logic [31:0] t_boot;
    logic [31:0] t_move;
    logic [31:0] t_main;
  } ahr_entry_t;

  typedef struct packed {
    logic [15:0] drv_temp;
    logic [15:0] mot_temp;
    logic [15:0] inv_volt;
    logic [31:0] din;
    logic [15:0] op_num;
    logic [15:0] op_kind;
    logic [31:0] fb_pos;
  } ahr_live_t;

  typedef struct packed {
    logic        start;
    logic        positioning;
    logic        uses_wrap;
    logic signed [32:0] travel;
    logic [31:0] op_speed;
    logic [31:0] st_speed;
    logic [31:0] push_speed;
    logic [31:0] push_cur;
    logic [31:0] home_max;
  } ahr_opreq_t;

  typedef struct packed {
    logic [31:0] op_speed;
    logic [31:0] st_speed;
    logic [31:0] push_speed;
    logic [31:0] push_cur;
    logic [31:0] home_max;
  } ahr_senslim_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01
  } ahr_op_state_t;
endpackage

// ===== logic/ahr_recorder.sv
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module ahr_recorder (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic                  ce,
  input  wire logic                  ctrl_pwr_present,
  input  wire logic                  ctrl_pwr_on,
  input  wire logic                  main_pwr_on,
  input  wire logic                  alarm_in,
  input  wire logic [7:0]            alarm_code_in,
  input  wire logic [7:0]            alarm_sub_in,
  input  wire ahr_pkg::ahr_live_t    live,
  input  wire logic [31:0]           rout_next,
  input  wire ahr_pkg::ahr_opreq_t   opreq,
  input  wire logic                  op_done,
  input  wire ahr_pkg::ahr_senslim_t senslim,
  output logic                       data_err,
  output logic [7:0]                 data_err_sub,
  output logic                       op_running,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o
);
  import ahr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  logic [31:0]       ctrl;
  logic [HIST_AW-1:0] sel;
  logic [31:0]       rout;
  logic              wb_req;
  logic              wb_wr;
  logic              sens_lim;
  logic              wrap_en;

  assign wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr    = wb_req && wb_we_i;
  assign sens_lim = ctrl[CTRL_SENSLIM];
  assign wrap_en  = ctrl[CTRL_WRAPEN];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= CTRL_RST;
    end else if (ce) begin
      ctrl[CTRL_CLR] <= 1'b0;
      if (wb_wr && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
        ctrl[7:0] <= wb_dat_i[7:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel <= '0;
    end else if (ce && wb_wr && wb_adr_i == REG_SEL && wb_sel_i[0]) begin
      sel <= wb_dat_i[HIST_AW-1:0];
    end
  end

  // Remote outputs kept live with no network in use
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rout <= '0;
    end else if (ce) begin
      rout <= rout_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operation data checks, first failing cause wins
  logic [7:0] next_sub;
  always_comb begin
    next_sub = SUB_NONE;
    if (opreq.start) begin
      if (opreq.positioning && (opreq.travel > TRAVEL_MAX || opreq.travel < TRAVEL_MIN)) begin
        next_sub = SUB_TRAVEL;
      end else if (opreq.uses_wrap && !wrap_en) begin
        next_sub = SUB_WRAP;
      end else if (opreq.positioning && opreq.travel != '0 && opreq.op_speed == '0) begin
        next_sub = SUB_ZSPEED;
      end else if (sens_lim && opreq.op_speed > senslim.op_speed) begin
        next_sub = SUB_OPSPD;
      end else if (sens_lim && opreq.st_speed > senslim.st_speed) begin
        next_sub = SUB_STSPD;
      end else if (sens_lim && opreq.push_speed > senslim.push_speed) begin
        next_sub = SUB_PSHSPD;
      end else if (sens_lim && opreq.push_cur > senslim.push_cur) begin
        next_sub = SUB_PSHCUR;
      end else if (sens_lim && opreq.home_max > senslim.home_max) begin
        next_sub = SUB_HOME;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      data_err     <= 1'b0;
      data_err_sub <= SUB_NONE;
    end else if (ce) begin
      data_err     <= next_sub != SUB_NONE;
      data_err_sub <= next_sub;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operation state; a rejected start never runs
  ahr_op_state_t op_state;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      op_state <= ST_IDLE;
    end else if (ce) begin
      unique case (op_state)
        ST_IDLE: begin
          if (opreq.start && next_sub == SUB_NONE) begin
            op_state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (op_done || alarm_in) begin
            op_state <= ST_IDLE;
          end
        end
      endcase
    end
  end
  assign op_running = op_state == ST_RUN;

  ////////////////////////////////////////////////////////////////////////////
  // Elapsed time counters in ticks
  logic [$clog2(TICK_CYC)-1:0] tick_cnt;
  logic                        tick;
  logic [31:0]                 t_boot;
  logic [31:0]                 t_move;
  logic [31:0]                 t_main;
  logic                        boot_on;

  assign tick    = tick_cnt == ($clog2(TICK_CYC))'(TICK_CYC - 1);
  assign boot_on = ctrl_pwr_present ? ctrl_pwr_on : main_pwr_on;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt <= '0;
    end else if (ce) begin
      tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      t_boot <= '0;
    end else if (ce) begin
      if (!boot_on) begin
        t_boot <= '0;
      end else if (tick) begin
        t_boot <= t_boot + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      t_main <= '0;
    end else if (ce) begin
      if (!main_pwr_on) begin
        t_main <= '0;
      end else if (tick) begin
        t_main <= t_main + 1'b1;
      end
    end
  end

  // Restarts at each accepted start
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      t_move <= '0;
    end else if (ce) begin
      if (op_state == ST_IDLE && opreq.start && next_sub == SUB_NONE) begin
        t_move <= '0;
      end else if (op_running && tick) begin
        t_move <= t_move + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Snapshot and circular history
  logic               alarm_q;
  logic               alarm_rise;
  logic [HIST_AW-1:0] wr_ptr;
  logic [HIST_AW:0]   count;
  ahr_entry_t         snap;
  ahr_entry_t         rd_entry;
  logic [HIST_AW-1:0] rd_addr;

  assign alarm_rise = alarm_in && !alarm_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      alarm_q <= 1'b0;
    end else if (ce) begin
      alarm_q <= alarm_in;
    end
  end

  // All fields taken from one cycle
  always_comb begin
    snap          = '0;
    snap.code     = alarm_code_in;
    snap.sub      = alarm_sub_in;
    snap.drv_temp = live.drv_temp;
    snap.mot_temp = live.mot_temp;
    snap.inv_volt = live.inv_volt;
    snap.din      = live.din;
    snap.rout     = rout;
    snap.op_num   = live.op_num;
    snap.op_kind  = live.op_kind;
    snap.fb_pos   = live.fb_pos;
    snap.t_boot   = t_boot;
    snap.t_move   = t_move;
    snap.t_main   = t_main;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      count  <= '0;
    end else if (ce) begin
      if (ctrl[CTRL_CLR] && !alarm_rise) begin
        count <= '0;
      end else if (alarm_rise) begin
        wr_ptr <= wr_ptr + 1'b1;
        if (count != (HIST_AW+1)'(HIST_DEPTH)) begin
          count <= count + 1'b1;
        end
      end
    end
  end

  // Index 0 is the newest entry
  assign rd_addr = wr_ptr - 1'b1 - sel;

  ahr_hist_mem u_mem (
    .clk   (clk),
    .ce    (ce),
    .we    (alarm_rise),
    .waddr (wr_ptr),
    .wdata (snap),
    .raddr (rd_addr),
    .rdata (rd_entry)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave, one wait state for the registered memory read
  logic        rd_wait;
  logic [31:0] next_dat;
  logic [3:0]  word;

  assign word = wb_adr_i[5:2];

  always_comb begin
    next_dat = '0;
    if (wb_adr_i >= REG_ENTRY) begin
      unique case (word)
        4'h0: next_dat = {16'h0000, rd_entry.code, rd_entry.sub};
        4'h1: next_dat = {16'h0000, rd_entry.drv_temp};
        4'h2: next_dat = {16'h0000, rd_entry.mot_temp};
        4'h3: next_dat = {16'h0000, rd_entry.inv_volt};
        4'h4: next_dat = rd_entry.din;
        4'h5: next_dat = rd_entry.rout;
        4'h6: next_dat = {16'h0000, rd_entry.op_num};
        4'h7: next_dat = {16'h0000, rd_entry.op_kind};
        4'h8: next_dat = rd_entry.fb_pos;
        4'h9: next_dat = rd_entry.t_boot;
        4'ha: next_dat = rd_entry.t_move;
        4'hb: next_dat = rd_entry.t_main;
        default: next_dat = '0;
      endcase
    end else begin
      unique case (wb_adr_i)
        REG_CTRL: next_dat = ctrl;
        REG_STAT: next_dat = {27'h0, op_running, count};
        REG_SEL:  next_dat = {29'h0, sel};
        REG_ROUT: next_dat = rout;
        default:  next_dat = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_wait  <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (ce) begin
      wb_ack_o <= 1'b0;
      if (wb_req && !rd_wait) begin
        rd_wait <= 1'b1;
      end else if (wb_req && rd_wait) begin
        rd_wait  <= 1'b0;
        wb_ack_o <= 1'b1;
        wb_dat_o <= next_dat;
      end else begin
        rd_wait <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_rout_live: assert property (@(posedge clk) disable iff (!rstn)
    ce |=> rout == $past(rout_next)) else $error("remote outputs not tracked");
  chk_sub_travel: assert property (@(posedge clk) disable iff (!rstn)
    ce && opreq.start && opreq.positioning && opreq.travel > TRAVEL_MAX
    |=> data_err && data_err_sub == SUB_TRAVEL) else $error("travel cause missed");
  chk_sub_wrap: assert property (@(posedge clk) disable iff (!rstn)
    ce && opreq.start && opreq.uses_wrap && !wrap_en
    && opreq.travel <= TRAVEL_MAX && opreq.travel >= TRAVEL_MIN
    |=> data_err_sub == SUB_WRAP) else $error("wrap cause missed");
  chk_sub_range: assert property (@(posedge clk) disable iff (!rstn)
    data_err |-> data_err_sub >= SUB_TRAVEL && data_err_sub <= SUB_HOME)
    else $error("sub code out of range");
  chk_no_senslim: assert property (@(posedge clk) disable iff (!rstn)
    ce && !sens_lim && opreq.start && !opreq.uses_wrap && opreq.op_speed != '0
    && opreq.travel <= TRAVEL_MAX && opreq.travel >= TRAVEL_MIN
    |=> !data_err) else $error("sensor limits applied while unselected");
  chk_ptr_advance: assert property (@(posedge clk) disable iff (!rstn)
    ce && alarm_rise |=> wr_ptr == $past(wr_ptr) + 1'b1) else $error("history ptr stuck");
  chk_count_cap: assert property (@(posedge clk) disable iff (!rstn)
    count <= (HIST_AW+1)'(HIST_DEPTH)) else $error("history count overflow");
  chk_move_reset: assert property (@(posedge clk) disable iff (!rstn)
    ce && op_state == ST_IDLE && opreq.start && next_sub == SUB_NONE
    |=> t_move == '0 && op_running) else $error("move timer not restarted");
  chk_main_off: assert property (@(posedge clk) disable iff (!rstn)
    ce && !main_pwr_on |=> t_main == '0) else $error("main timer not cleared");
  chk_ack_pulse: assert property (@(posedge clk) disable iff (!rstn)
    wb_ack_o |=> !wb_ack_o) else $error("ack held");

  cov_alarm: cover property (@(posedge clk) disable iff (!rstn) alarm_rise && ce);
  cov_wrap: cover property (@(posedge clk) disable iff (!rstn) count == 4'(HIST_DEPTH)
    && alarm_rise);
  cov_home: cover property (@(posedge clk) disable iff (!rstn) data_err_sub == SUB_HOME);
  cov_read: cover property (@(posedge clk) disable iff (!rstn) wb_ack_o && !wb_we_i);
endmodule

// ===== tb/tb_ahr_recorder.sv
`timescale 1ns/1ps
module tb_ahr_recorder;
  import ahr_pkg::*;
  typedef struct {string nm; logic [31:0] ex; logic [31:0] mk;} ahr_note_t;
  ////////////////////////////////////////////////////////////////////////////
  logic          clk;
  logic          rstn;
  logic          ce;
  logic          ctrl_pwr_present;
  logic          ctrl_pwr_on;
  logic          main_pwr_on;
  logic          alarm_in;
  logic [7:0]    alarm_code_in;
  logic [7:0]    alarm_sub_in;
  ahr_live_t     live;
  logic [31:0]   rout_next;
  ahr_opreq_t    opreq;
  logic          op_done;
  ahr_senslim_t  senslim;
  logic          data_err;
  logic [7:0]    data_err_sub;
  logic          op_running;
  logic          wb_cyc_i;
  logic          wb_stb_i;
  logic          wb_we_i;
  logic [7:0]    wb_adr_i;
  logic [3:0]    wb_sel_i;
  logic [31:0]   wb_dat_i;
  logic [31:0]   wb_dat_o;
  logic          wb_ack_o;
  ahr_note_t     rd_q[$];
  logic [8:0]    op_q[$];
  logic          start_seen;
  int            err_total;
  int            n_compared;
  int            cyc_cnt;
  int unsigned   seed;
  ahr_live_t     lv;
  logic [31:0]   lr;
  logic [7:0]    ls;
  ////////////////////////////////////////////////////////////////////////////
  ahr_recorder DUT (
    .clk(clk), .rstn(rstn), .ce(ce), .ctrl_pwr_present(ctrl_pwr_present),
    .ctrl_pwr_on(ctrl_pwr_on), .main_pwr_on(main_pwr_on), .alarm_in(alarm_in),
    .alarm_code_in(alarm_code_in), .alarm_sub_in(alarm_sub_in), .live(live),
    .rout_next(rout_next), .opreq(opreq), .op_done(op_done), .senslim(senslim),
    .data_err(data_err), .data_err_sub(data_err_sub), .op_running(op_running),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
  );

  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    n_compared++;
    if (seen !== ex) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Classic single cycle; held until ack is seen at a rising edge
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= 4'hf;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    @(posedge clk);
    while (wb_ack_o !== 1'b1) @(posedge clk);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic rd(input string nm, input logic [7:0] adr, input logic [31:0] ex,
                    input logic [31:0] mk);
    rd_q.push_back('{nm, ex & mk, mk});
    wb(1'b0, adr, 32'h0000_0000);
  endtask

  // Pulse per start; op_done afterwards so the next start finds the block idle
  task automatic start_op(input ahr_opreq_t r, input logic [7:0] sub);
    op_q.push_back({sub != 8'h00, sub});
    @(posedge clk);
    opreq <= r;
    @(posedge clk);
    opreq.start <= 1'b0;
    @(posedge clk);
    op_done <= 1'b1;
    @(posedge clk);
    op_done <= 1'b0;
  endtask

  // k selects which single limit is broken, except 10 breaks travel and op speed together; 0 is a clean request
  function automatic ahr_opreq_t make_req(input int k);
    ahr_opreq_t r;
    r = '0;
    r.start = 1'b1;
    r.positioning = 1'b1;
    r.travel = 33'sd100;
    r.op_speed = 32'($urandom_range(1, 5000));
    r.st_speed = 32'($urandom_range(1, 5000));
    r.push_speed = 32'($urandom_range(0, 5000));
    r.push_cur = 32'($urandom_range(0, 5000));
    r.home_max = 32'($urandom_range(0, 5000));
    case (k)
      1: r.travel = TRAVEL_MAX + 33'sd1;
      2: r.uses_wrap = 1'b1;
      3: r.op_speed = 32'h0000_0000;
      4: r.op_speed = 32'd5001;
      5: r.st_speed = 32'd5001;
      6: r.push_speed = 32'd5001;
      7: r.push_cur = 32'd5001;
      8: r.home_max = 32'd5001;
      9: r.travel = TRAVEL_MIN - 33'sd1;
      10: begin
        r.travel = TRAVEL_MAX + 33'sd1;
        r.op_speed = 32'h0000_0000;
      end
      default: ;
    endcase
    return r;
  endfunction

  // Fields change right after the sampling edge to catch a late capture
  task automatic alarm(input logic [7:0] c);
    lv = {$urandom, $urandom, $urandom, $urandom, 16'($urandom)};
    lr = $urandom;
    ls = 8'($urandom);
    @(posedge clk);
    rout_next <= lr;
    repeat (2) @(posedge clk);
    alarm_in <= 1'b1;
    alarm_code_in <= c;
    alarm_sub_in <= ls;
    live <= lv;
    @(posedge clk);
    alarm_in <= 1'b0;
    live <= ~lv;
    rout_next <= ~lr;
    alarm_sub_in <= ~ls;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (start_seen) begin
      if (op_q.size() == 0) check("op_q", 32'h1, 32'h0);
      else check("data_err", {23'h0, data_err, data_err_sub}, {23'h0, op_q.pop_front()});
    end
    start_seen <= opreq.start & rstn;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (rd_q.size() == 0) check("rd_q", 32'h1, 32'h0);
      else begin
        ahr_note_t n;
        n = rd_q.pop_front();
        check(n.nm, wb_dat_o & n.mk, n.ex);
      end
    end
  end

  // Whole run is a few hundred cycles
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_total++;
      $display("timeout");
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 0; rstn = 0; ce = 1; ctrl_pwr_present = 1; ctrl_pwr_on = 1;
    main_pwr_on = 1; alarm_in = 0; alarm_code_in = 8'h00; alarm_sub_in = 8'h00;
    live = '0; rout_next = 32'h0; opreq = '0; op_done = 0; start_seen = 0;
    senslim = {5{32'd5000}};
    wb_cyc_i = 0; wb_stb_i = 0; wb_we_i = 0; wb_adr_i = 8'h00;
    wb_sel_i = 4'hf; wb_dat_i = 32'h0;
    err_total = 0; n_compared = 0; cyc_cnt = 0;
    seed = $urandom(20981);
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rd("stat", REG_STAT, 32'h0, 32'h1f);
    rd("ctrl", REG_CTRL, 32'h0, 32'h7);
    wb(1'b1, 8'h30, 32'hffff_ffff);
    rd("unmapped", 8'h30, 32'h0, 32'hffff_ffff);
    $display("test reset and map done");
    wb(1'b1, REG_CTRL, 32'h2);
    rd("ctrl", REG_CTRL, 32'h2, 32'h7);
    for (int k = 1; k <= 8; k++) start_op(make_req(k), 8'(k));
    start_op(make_req(9), SUB_TRAVEL);
    start_op(make_req(10), SUB_TRAVEL);
    start_op(make_req(0), SUB_NONE);
    wb(1'b1, REG_CTRL, 32'h0);
    for (int k = 4; k <= 8; k++) start_op(make_req(k), SUB_NONE);
    start_op(make_req(2), SUB_WRAP);
    wb(1'b1, REG_CTRL, 32'h4);
    start_op(make_req(2), SUB_NONE);
    $display("test data error causes done");
    @(posedge clk);
    opreq <= make_req(0);
    @(posedge clk);
    opreq.start <= 1'b0;
    op_q.push_back(9'h000);
    rd("running", REG_STAT, 32'h10, 32'h10);
    @(posedge clk);
    op_done <= 1'b1;
    @(posedge clk);
    op_done <= 1'b0;
    rd("stopped", REG_STAT, 32'h0, 32'h10);
    lr = $urandom;
    @(posedge clk);
    rout_next <= lr;
    rd("rout live", REG_ROUT, lr, 32'hffff_ffff);
    $display("test running and remote outputs done");
    for (int i = 1; i <= 9; i++) alarm(8'h10 + 8'(i));
    // Alarm edge while frozen must not land in the history
    @(posedge clk);
    ce <= 1'b0;
    main_pwr_on <= 1'b0;
    alarm_in <= 1'b1;
    alarm_code_in <= 8'h55;
    @(posedge clk);
    alarm_in <= 1'b0;
    @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    main_pwr_on <= 1'b1;
    rd("count", REG_STAT, 32'h8, 32'hf);
    wb(1'b1, REG_SEL, 32'h0);
    rd("code", REG_ENTRY, {16'h0, 8'h19, ls}, 32'hffff);
    rd("drv_temp", REG_ENTRY + 8'h04, {16'h0, lv.drv_temp}, 32'hffff);
    rd("mot_temp", REG_ENTRY + 8'h08, {16'h0, lv.mot_temp}, 32'hffff);
    rd("inv_volt", REG_ENTRY + 8'h0c, {16'h0, lv.inv_volt}, 32'hffff);
    rd("din", REG_ENTRY + 8'h10, lv.din, 32'hffff_ffff);
    rd("rout", REG_ENTRY + 8'h14, lr, 32'hffff_ffff);
    rd("op_num", REG_ENTRY + 8'h18, {16'h0, lv.op_num}, 32'hffff);
    rd("op_kind", REG_ENTRY + 8'h1c, {16'h0, lv.op_kind}, 32'hffff);
    rd("fb_pos", REG_ENTRY + 8'h20, lv.fb_pos, 32'hffff_ffff);
    // Run stays far below one 1 ms tick, so every timer still reads zero
    rd("t_boot", REG_ENTRY + 8'h24, 32'h0, 32'hffff_ffff);
    rd("t_move", REG_ENTRY + 8'h28, 32'h0, 32'hffff_ffff);
    rd("t_main", REG_ENTRY + 8'h2c, 32'h0, 32'hffff_ffff);
    wb(1'b1, REG_SEL, 32'h7);
    rd("oldest", REG_ENTRY, {16'h0, 8'h12, 8'h00}, 32'hff00);
    wb(1'b1, REG_SEL, 32'h1);
    rd("second", REG_ENTRY, {16'h0, 8'h18, 8'h00}, 32'hff00);
    wb(1'b1, REG_CTRL, 32'h1);
    rd("cleared", REG_STAT, 32'h0, 32'hf);
    $display("test alarm history done");
    repeat (4) @(posedge clk);
    complete_run();
  end
endmodule
